// File: rtl/gpb_pkg.sv
// gpb_pkg: constants shared by the GPIO port bank and its port slices.
// assumes one 100 MHz system clock and an 8-bit register access port.
package gpb_pkg;
    localparam int NUM_PORTS = 9;
    localparam int PORT_W = 8;
    localparam int PIN_W = NUM_PORTS * PORT_W;
    localparam int CLK_NS = 10;
    localparam int SYNC_STAGES = 2;
    // port order A B C D E F G H J
    localparam logic [3:0] IDX_B = 4'h1;
    localparam logic [3:0] IDX_D = 4'h3;
    localparam logic [3:0] IDX_E = 4'h4;
    localparam logic [3:0] IDX_G = 4'h6;
    localparam logic [3:0] IDX_H = 4'h7;
    localparam logic [3:0] IDX_J = 4'h8;
    // register select within a port
    localparam logic [1:0] SEL_DIR = 2'h0;
    localparam logic [1:0] SEL_PIN = 2'h1;
    localparam logic [1:0] SEL_LAT = 2'h2;
    localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
    localparam logic [PORT_W-1:0] LAT_RST = 8'h00;
    localparam logic [PORT_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic PU_RST = 1'b0;
    localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PORT_MASK = {
        8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam int PUB_BIT = 7;
    localparam int PUJ_BIT = 5;
    localparam int PUE_BIT = 6;
    localparam int PUD_BIT = 7;
endpackage : gpb_pkg

// File: rtl/gpb_port_if.sv
// gpb_port_if: signals between the bank controller and one port slice.
// assumes both ends share clk_sys.
`timescale 1ns/100ps
interface gpb_port_if;
    import gpb_pkg::*;
    logic wr_dir;
    logic wr_lat;
    logic [PORT_W-1:0] wr_data;
    logic [PORT_W-1:0] pin_raw;
    logic [PORT_W-1:0] periph_en;
    logic [PORT_W-1:0] periph_out;
    logic [PORT_W-1:0] periph_oe;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] lat;
    logic [PORT_W-1:0] pin_lvl;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    modport ctrl (output wr_dir, wr_lat, wr_data, pin_raw, periph_en,
        periph_out, periph_oe, input dir, lat, pin_lvl, pin_out, pin_oe);
    modport port (input wr_dir, wr_lat, wr_data, pin_raw, periph_en,
        periph_out, periph_oe, output dir, lat, pin_lvl, pin_out, pin_oe);
endinterface : gpb_port_if

// File: rtl/gpb_port.sv
// gpb_port: one 8-bit port slice with direction, latch and pin sampler.
// assumes pin_raw is asynchronous and writes are one-cycle strobes.
`timescale 1ns/100ps
module gpb_port
    import gpb_pkg::*;
#(
    parameter logic [PORT_W-1:0] MASK = 8'hFF,
    parameter bit PRESENT = 1'b1
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    gpb_port_if.port bus // link to the bank controller
);
    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] lat;
        logic [PORT_W-1:0] sync1;
        logic [PORT_W-1:0] sync2;
    } gpb_slice_t;

    localparam logic [PORT_W-1:0] LIVE = PRESENT ? MASK : ZERO_BYTE;

    gpb_slice_t st_reg;
    gpb_slice_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = bus.pin_raw & LIVE;
        st_next.sync2 = st_reg.sync1;
        if (bus.wr_dir) begin
            st_next.dir = bus.wr_data & LIVE;
        end
        if (bus.wr_lat) begin
            st_next.lat = bus.wr_data & LIVE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg <= '{DIR_RST & LIVE, LAT_RST, ZERO_BYTE, ZERO_BYTE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.dir = st_reg.dir;
    assign bus.lat = st_reg.lat;
    assign bus.pin_lvl = st_reg.sync2;
    assign bus.pin_out = LIVE & ((bus.periph_en & bus.periph_out)
        | (~bus.periph_en & st_reg.lat));
    assign bus.pin_oe = LIVE & ((bus.periph_en & bus.periph_oe)
        | (~bus.periph_en & ~st_reg.dir));

    sequence s_wr_latch;
        bus.wr_lat && !bus.wr_dir;
    endsequence

    property p_pin_sample;
        @(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n, 2) && $past(reset_n)
        |-> bus.pin_lvl == ($past(bus.pin_raw, 2) & LIVE);
    endproperty
    a_pin_sample: assert property (p_pin_sample)
        else $error("pin level not the two-cycle sample");

    property p_latch_write;
        @(posedge clk_sys) disable iff (!reset_n)
        s_wr_latch |=> bus.lat == ($past(bus.wr_data) & LIVE);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch missed a write");

    property p_tristate;
        @(posedge clk_sys) disable iff (!reset_n)
        ((bus.pin_oe & ~bus.periph_en & bus.dir) == ZERO_BYTE);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("input pin is being driven");

    property p_drive;
        @(posedge clk_sys) disable iff (!reset_n)
        (((~bus.periph_en & ~bus.dir & LIVE) & ~(bus.pin_oe &
        ~(bus.pin_out ^ bus.lat))) == ZERO_BYTE);
    endproperty
    a_drive: assert property (p_drive)
        else $error("output pin not driving latch value");

    property p_latch_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        !bus.wr_lat ##1 !bus.wr_lat |-> $stable(bus.lat);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed without a write");

    property p_periph;
        @(posedge clk_sys) disable iff (!reset_n)
        (((bus.periph_en & LIVE) & ((bus.pin_out ^ bus.periph_out)
        | (bus.pin_oe ^ bus.periph_oe))) == ZERO_BYTE);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral lost control of its pin");

    property p_unimpl;
        @(posedge clk_sys) disable iff (!reset_n)
        ((bus.dir | bus.lat | bus.pin_lvl | bus.pin_oe) & ~LIVE) == ZERO_BYTE;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bit is live");
endmodule // gpb_port

// File: rtl/gpb_bank.sv
// gpb_bank: nine-port GPIO bank with register access and pull-up enables.
// assumes a host drives one-cycle read and write strobes on clk_sys;
// pins arrive asynchronously and are synchronised per port.
`timescale 1ns/100ps
module gpb_bank
    import gpb_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic reset_n, // synchronous reset, active low
    input wire logic cpu_wr_en, // register write strobe
    input wire logic cpu_rd_en, // register read strobe
    input wire logic [3:0] cpu_port, // port index, A=0 .. J=8
    input wire logic [1:0] cpu_sel, // 0 dir, 1 pin, 2 latch
    input wire logic [PORT_W-1:0] cpu_wr_data, // write data
    output logic [PORT_W-1:0] cpu_rd_data, // read data, registered
    input wire logic [PORT_W-1:0] int_ctrl_reg_2, // interrupt control 2
    input wire logic [PIN_W-1:0] pin_in, // pad input levels
    output logic [PIN_W-1:0] pin_out, // pad output values
    output logic [PIN_W-1:0] pin_oe, // pad output enables
    input wire logic [PIN_W-1:0] periph_en, // peripheral owns pin
    input wire logic [PIN_W-1:0] periph_out, // peripheral output
    input wire logic [PIN_W-1:0] periph_oe, // peripheral enable
    output logic [PIN_W-1:0] pullup_en // weak pull-up on
);
    typedef struct packed {
        logic pu_d;
        logic pu_e;
        logic pu_j;
        logic [PORT_W-1:0] rd_data;
    } gpb_ctrl_t;

    function automatic logic hit(input logic [3:0] port, input int idx);
        return port == idx[3:0];
    endfunction

    function automatic logic present(input int idx);
        return LARGE_PKG || (idx != int'(IDX_H) && idx != int'(IDX_J));
    endfunction

    gpb_ctrl_t st_reg;
    gpb_ctrl_t st_next;
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir_v;
    logic [NUM_PORTS-1:0][PORT_W-1:0] lat_v;
    logic [NUM_PORTS-1:0][PORT_W-1:0] lvl_v;
    logic [NUM_PORTS-1:0] pu_v;
    logic port_b_pu;

    // port B enable from control bit
    assign port_b_pu = int_ctrl_reg_2[PUB_BIT];

    always_comb begin
        pu_v = '0;
        pu_v[IDX_B] = port_b_pu;
        pu_v[IDX_D] = st_reg.pu_d;
        pu_v[IDX_E] = st_reg.pu_e;
        pu_v[IDX_J] = st_reg.pu_j & LARGE_PKG;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            gpb_port_if pif();
            localparam bit PRES = present(gi);
            assign pif.wr_dir = cpu_wr_en && hit(cpu_port, gi)
                && cpu_sel == SEL_DIR;
            assign pif.wr_lat = cpu_wr_en && hit(cpu_port, gi)
                && (cpu_sel == SEL_PIN || cpu_sel == SEL_LAT);
            assign pif.wr_data = cpu_wr_data;
            assign pif.pin_raw = pin_in[gi*PORT_W +: PORT_W];
            assign pif.periph_en = periph_en[gi*PORT_W +: PORT_W];
            assign pif.periph_out = periph_out[gi*PORT_W +: PORT_W];
            assign pif.periph_oe = periph_oe[gi*PORT_W +: PORT_W];
            assign dir_v[gi] = pif.dir;
            assign lat_v[gi] = pif.lat;
            assign lvl_v[gi] = pif.pin_lvl;
            assign pin_out[gi*PORT_W +: PORT_W] = pif.pin_out;
            assign pin_oe[gi*PORT_W +: PORT_W] = pif.pin_oe;
            assign pullup_en[gi*PORT_W +: PORT_W] =
                {PORT_W{pu_v[gi]}} & ~pif.pin_oe;
            // H and J vanish on small variant
            gpb_port #(
                .MASK(PORT_MASK[gi]),
                .PRESENT(PRES)
            ) u_port (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .bus(pif)
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        // upper port G pin bits hold pull-ups
        if (cpu_wr_en && cpu_port == IDX_G && cpu_sel == SEL_PIN) begin
            st_next.pu_d = cpu_wr_data[PUD_BIT];
            st_next.pu_e = cpu_wr_data[PUE_BIT];
            st_next.pu_j = cpu_wr_data[PUJ_BIT] & LARGE_PKG;
        end
        if (cpu_rd_en) begin
            st_next.rd_data = ZERO_BYTE;
            if (cpu_port < NUM_PORTS[3:0]) begin
                unique case (cpu_sel)
                    SEL_DIR: st_next.rd_data = dir_v[cpu_port];
                    SEL_PIN: st_next.rd_data = lvl_v[cpu_port];
                    SEL_LAT: st_next.rd_data = lat_v[cpu_port];
                    default: st_next.rd_data = ZERO_BYTE;
                endcase
                if (cpu_port == IDX_G && cpu_sel == SEL_PIN) begin
                    st_next.rd_data[PUJ_BIT] = st_reg.pu_j;
                    st_next.rd_data[PUE_BIT] = st_reg.pu_e;
                    st_next.rd_data[PUD_BIT] = st_reg.pu_d;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg <= '{PU_RST, PU_RST, PU_RST, ZERO_BYTE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cpu_rd_data = st_reg.rd_data;

    sequence s_rd_lat;
        cpu_rd_en && cpu_sel == SEL_LAT && cpu_port < NUM_PORTS[3:0];
    endsequence

    property p_rd_lat;
        @(posedge clk_sys) disable iff (!reset_n)
        s_rd_lat |=> cpu_rd_data == $past(lat_v[cpu_port]);
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("latch read returned wrong value");

    property p_pu_b;
        @(posedge clk_sys) disable iff (!reset_n)
        (pullup_en[IDX_B*PORT_W +: PORT_W] ==
        ({PORT_W{int_ctrl_reg_2[PUB_BIT]}}
        & ~pin_oe[IDX_B*PORT_W +: PORT_W]));
    endproperty
    a_pu_b: assert property (p_pu_b)
        else $error("port B pull-up not following control bit");

    sequence s_wr_pin_g;
        cpu_wr_en && cpu_port == IDX_G && cpu_sel == SEL_PIN;
    endsequence

    sequence s_rd_pin_g;
        cpu_rd_en && !cpu_wr_en && cpu_port == IDX_G && cpu_sel == SEL_PIN;
    endsequence

    property p_pu_g;
        @(posedge clk_sys) disable iff (!reset_n)
        s_wr_pin_g ##1 s_rd_pin_g |=>
        cpu_rd_data[PUD_BIT] == $past(cpu_wr_data[PUD_BIT], 2)
        && cpu_rd_data[PUE_BIT] == $past(cpu_wr_data[PUE_BIT], 2)
        && cpu_rd_data[PUJ_BIT] == ($past(cpu_wr_data[PUJ_BIT], 2)
        & LARGE_PKG);
    endproperty
    a_pu_g: assert property (p_pu_g)
        else $error("port G pull-up bits not read back");

    property p_pu_none;
        @(posedge clk_sys) disable iff (!reset_n)
        pullup_en[IDX_G*PORT_W +: PORT_W] == ZERO_BYTE
        && pullup_en[0 +: PORT_W] == ZERO_BYTE;
    endproperty
    a_pu_none: assert property (p_pu_none)
        else $error("pull-up on a port without them");

    property p_absent;
        @(posedge clk_sys) disable iff (!reset_n)
        !LARGE_PKG |-> pin_oe[IDX_H*PORT_W +: 2*PORT_W] == '0;
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent port is driving");
endmodule // gpb_bank

// File: dv/gpb_pins_model.sv
// gpb_pins_model: external circuits on the 72 pads of the port bank.
// assumes the bench sets what outside logic drives; pads never left floating
// in sim: pull-up gives one, otherwise a pattern that flips every cycle.
`timescale 1ns/100ps
module gpb_pins_model
    import gpb_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic [PIN_W-1:0] pin_out, // device pad values
    input wire logic [PIN_W-1:0] pin_oe, // device drives pad
    input wire logic [PIN_W-1:0] pullup_en, // device weak pull-up
    input wire logic [PIN_W-1:0] ext_val, // outside logic value
    input wire logic [PIN_W-1:0] ext_oe, // outside logic drives
    output logic [PIN_W-1:0] pin_in // resolved pad level
);
    logic flip_reg = 1'b0;

    always_ff @(posedge clk_sys) begin
        flip_reg <= ~flip_reg;
    end

    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_oe[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flip_reg ^ i[0];
        end
    end
endmodule // gpb_pins_model

// File: dv/gpb_bank_tb_top.sv
// gpb_bank_tb_top: self-checking bench for the nine-port bank.
// assumes the large variant, a small one beside it; reads via a queue.
`timescale 1ns/100ps
module gpb_bank_tb_top;
    import gpb_pkg::*;
    localparam int LIMIT = 3000;
    logic clk_sys = 1'b0, reset_n = 1'b0, cpu_wr_en = 1'b0, cpu_rd_en = 1'b0;
    logic [3:0] cpu_port = 4'h0;
    logic [1:0] cpu_sel = 2'h0;
    logic [7:0] cpu_wr_data = 8'h00, cpu_rd_data, int_ctrl_reg_2 = 8'h00;
    logic [PIN_W-1:0] pin_in, pin_out, pin_oe, pullup_en;
    logic [PIN_W-1:0] oe_small, pu_small;
    logic [PIN_W-1:0] periph_en = '0, periph_out = '0, periph_oe = '0;
    logic [PIN_W-1:0] ext_val = '0, ext_oe = '1;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    int err_count = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'h0000_003F;
    logic [7:0] v, e, m;

    gpb_bank #(.LARGE_PKG(1'b1)) gpb_bank_inst (.clk_sys(clk_sys),
        .reset_n(reset_n), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en),
        .cpu_port(cpu_port), .cpu_sel(cpu_sel), .cpu_wr_data(cpu_wr_data),
        .cpu_rd_data(cpu_rd_data), .int_ctrl_reg_2(int_ctrl_reg_2),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_en(periph_en), .periph_out(periph_out),
        .periph_oe(periph_oe), .pullup_en(pullup_en));
    // small variant on the same stimulus, H and J absent
    gpb_bank #(.LARGE_PKG(1'b0)) gpb_bank_small_inst (.clk_sys(clk_sys),
        .reset_n(reset_n), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en),
        .cpu_port(cpu_port), .cpu_sel(cpu_sel), .cpu_wr_data(cpu_wr_data),
        .cpu_rd_data(), .int_ctrl_reg_2(int_ctrl_reg_2),
        .pin_in(pin_in), .pin_out(), .pin_oe(oe_small),
        .periph_en(periph_en), .periph_out(periph_out),
        .periph_oe(periph_oe), .pullup_en(pu_small));
    gpb_pins_model gpb_pins_model_inst (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_val(ext_val),
        .ext_oe(ext_oe), .pin_in(pin_in));

    always #5 clk_sys = ~clk_sys;

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic report(string what, logic [7:0] ex, logic [7:0] got);
        compares++;
        if (got !== ex) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, ex, got);
        end
    endtask

    task automatic chk_rd(logic [7:0] ex, logic [7:0] got);
        report("cpu_rd_data", ex, got);
    endtask

    task automatic chk_pad(string what, logic [7:0] ex, logic [7:0] got);
        report(what, ex, got);
    endtask

    // one register access per edge; reads leave a note in the queue
    task automatic acc(logic w, logic r, logic [3:0] p, logic [1:0] s,
        logic [7:0] d, logic [7:0] ex);
        @(posedge clk_sys);
        cpu_wr_en <= w;
        cpu_rd_en <= r;
        cpu_port <= p;
        cpu_sel <= s;
        cpu_wr_data <= d;
        if (r)
            exp_q.push_back(ex);
    endtask

    task automatic idle(int n);
        repeat (n) begin
            @(posedge clk_sys);
            cpu_wr_en <= 1'b0;
            cpu_rd_en <= 1'b0;
        end
        @(negedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        rd_seen <= cpu_rd_en & reset_n;
    end

    always @(negedge clk_sys) begin
        if (rd_seen)
            chk_rd(exp_q.pop_front(), cpu_rd_data);
    end

    task automatic results();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < PIN_W / 8; i++)
            ext_val[8*i +: 8] <= rnd();
        for (int p = 0; p < NUM_PORTS; p++) begin
            m = PORT_MASK[p];
            acc(1'b0, 1'b1, p[3:0], SEL_DIR, 8'h00, DIR_RST & m);
            acc(1'b0, 1'b1, p[3:0], SEL_LAT, 8'h00, LAT_RST);
        end
        acc(1'b0, 1'b1, 4'h9, SEL_DIR, 8'h00, ZERO_BYTE);
        acc(1'b0, 1'b1, 4'h0, 2'h3, 8'h00, ZERO_BYTE);
        idle(2);
        $display("test reset values done");
        e = {3'b111, ext_val[8*IDX_G +: 5]};
        acc(1'b1, 1'b0, IDX_G, SEL_PIN, 8'hE0, 8'h00);
        int_ctrl_reg_2 <= 8'h80;
        acc(1'b0, 1'b1, IDX_G, SEL_PIN, 8'h00, e);
        acc(1'b1, 1'b0, IDX_B, SEL_DIR, 8'h0F, 8'h00);
        idle(4);
        chk_pad("pullup_b", 8'h0F, pullup_en[8*IDX_B +: 8]);
        chk_pad("pullup_d", 8'hFF, pullup_en[8*IDX_D +: 8]);
        chk_pad("pullup_e", 8'hFF, pullup_en[8*IDX_E +: 8]);
        chk_pad("pullup_j", 8'hFF, pullup_en[8*IDX_J +: 8]);
        chk_pad("pullup_a", 8'h00, pullup_en[7:0]);
        chk_pad("small_pu_j", 8'h00, pu_small[8*IDX_J +: 8]);
        acc(1'b1, 1'b0, IDX_B, SEL_DIR, 8'hFF, 8'h00);
        idle(1);
        $display("test pull-ups done");
        for (int p = 0; p < NUM_PORTS; p++) begin
            v = rnd();
            e = rnd();
            m = PORT_MASK[p];
            if (p == IDX_G)
                acc(1'b1, 1'b0, p[3:0], SEL_LAT, v, 8'h00);
            else
                acc(1'b1, 1'b0, p[3:0], SEL_PIN, v, 8'h00);
            ext_val[8*p +: 8] <= e;
            idle(3);
            chk_pad("pin_oe", 8'h00, pin_oe[8*p +: 8]);
            if (p == IDX_G)
                acc(1'b0, 1'b1, p[3:0], SEL_PIN, 8'h00, {3'b111, e[4:0]});
            else
                acc(1'b0, 1'b1, p[3:0], SEL_PIN, 8'h00, e);
            acc(1'b0, 1'b1, p[3:0], SEL_LAT, 8'h00, v & PORT_MASK[p]);
            acc(1'b1, 1'b0, p[3:0], SEL_DIR, 8'h00, 8'h00);
            idle(3);
            chk_pad("pin_out", v & m, pin_out[8*p +: 8] & m);
            chk_pad("pin_oe", PORT_MASK[p], pin_oe[8*p +: 8] & PORT_MASK[p]);
            if (p != IDX_G)
                acc(1'b0, 1'b1, p[3:0], SEL_PIN, 8'h00, v);
        end
        idle(2);
        chk_pad("small_oe_h", 8'h00, oe_small[8*IDX_H +: 8]);
        chk_pad("small_oe_j", 8'h00, oe_small[8*IDX_J +: 8]);
        $display("test direction and latch done");
        acc(1'b1, 1'b0, 4'h2, SEL_LAT, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 4'h2, SEL_DIR, 8'h01, 8'h00);
        idle(1);
        chk_pad("open_drain_oe", 8'hFE, pin_oe[23:16]);
        chk_pad("open_drain_out", 8'h00, pin_out[23:16]);
        v = rnd();
        @(posedge clk_sys);
        periph_en[23:16] <= 8'hFF;
        periph_out[23:16] <= v;
        periph_oe[23:16] <= 8'h0F;
        idle(1);
        chk_pad("periph_out", v, pin_out[23:16]);
        chk_pad("periph_oe", 8'h0F, pin_oe[23:16]);
        $display("test peripheral override done");
        idle(2);
        results();
    end
endmodule // gpb_bank_tb_top
